/* File: verilog/wrc_weigh_relay.sv */
// Command interpreter and status generator of the weighing module
// Contract
// - Tare edge nulls net, optionally only stable
// - Tare cancel edge disables, keeps tare value
// - Zeroing edge clears gross or flags error
// - Zeroing cancel disables zero, clears error
// - Hold bit freezes weight and comparisons
// - Relay-sourced tare follows digital tare bit
// - Relay-sourced direction: 1 discharge, 0 feed
// - Relay-sourced fall compensation follows its bit
// - External judge bit gates judgments in simple mode
// - Start edge begins sequence in sequence mode
// - Stop edge aborts with error; again clears
// - Soft lock rejects calibration setting changes
// - Calibration edges ignored when locked or busy
// - Request edge moves twenty-word settings block
// - Sign bits mark negative gross and net
// - Two-bit decimal point position code
// - Near zero when weight at most setting
// - Simple mode set points compare against final
// - Sequence start sets flags; thresholds clear them
// - Complete on third flag fall, rearm below quarter
// - Under, go, over judgments; sequence freezes weight
// - Lower and upper limit flags, continuous or gated
`timescale 1ns/100ps
module wrc_weigh_relay
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [17:0] gross_raw,
	input  wire logic        stable_in,
	input  wire logic        lock_switch,
	input  wire logic        center_interval_flag,
	input  wire logic [3:0]  dip_sw
);
	typedef struct packed {
		logic               pready_r;
		logic               pslverr_r;
		logic [31:0]        prdata_r;
		logic [15:0]        cmd0_r;
		logic [15:0]        cmd1_r;
		logic [31:0]        cfg_r;
		logic [19:0][15:0]  mbox_r;
		logic [19:0][15:0]  live_r;
		logic [17:0]        zero_off_r;
		logic [17:0]        tare_r;
		logic [17:0]        gross_r;
		logic [17:0]        net_r;
		logic [17:0]        judge_w_r;
		logic [16:0]        calz_r;
		logic [16:0]        cals_r;
		logic               tare_on_r;
		logic               zeroing_trigger_r;
		logic               zero_err_r;
		wrc_pkg::wrc_seq_t  seq_r;
		logic [2:0]         sp_r;
		logic               complete_r;
		logic               armed_r;
		logic [2:0]         ou_r;
		logic               upper_r;
		logic               lower_r;
		logic               near_r;
		logic [3:0]         asst_r;
		logic [3:0]         code_r;
		logic               cal_zero_r;
		logic               cal_span_r;
		logic [7:0]         cal_cnt_r;
		logic               xf_busy_r;
		logic               xf_wr_r;
		logic [4:0]         xf_idx_r;
	} wrc_state_t;

	wrc_state_t        st_r;
	wrc_state_t        st_nxt;
	logic [31:0]       rise;
	logic [17:0]       gross_live;
	logic [17:0]       net_live;
	logic signed [18:0] w;
	logic signed [18:0] fin;
	logic signed [18:0] t1;
	logic signed [18:0] t2;
	logic signed [18:0] t3;
	logic signed [18:0] ov_t;
	logic signed [18:0] un_t;
	logic signed [18:0] quart;
	logic              ffc_en;
	logic              discharge;
	logic              tare_act;
	logic              hold;
	logic              freeze;
	logic              cal_busy;
	logic              dz_ok;
	logic              soft_lock;
	logic              near_cmp;
	logic [2:0]        sp_cmp;
	logic [19:0]       gbcd;
	logic [19:0]       nbcd;
	logic [31:0]       stg;
	logic [31:0]       stn;
	logic [31:0]       stm;
	logic [7:0]        mb_off;
	logic              mb_hit;
	logic              acc_wr;

	function automatic logic [16:0] setv(input logic [19:0][15:0] l, input int i);
		return {l[i + 1][0], l[i]};
	endfunction

	function automatic logic signed [18:0] u19(input logic [16:0] v);
		return {2'b00, v};
	endfunction

	function automatic logic [16:0] mag(input logic [17:0] v);
		logic [17:0] a;
		a = v[17] ? -v : v;
		return a[16:0];
	endfunction

	// Returns {over, go, under}
	function automatic logic [2:0] ouj(input logic signed [18:0] v, hi, lo, gl);
		return {v > hi, (v <= hi) && (v >= gl), v < lo};
	endfunction

	wrc_edge u_edge
	(
		.pclk    (pclk),
		.presetn (presetn),
		.bits    ({st_r.cmd1_r, st_r.cmd0_r}),
		.rise    (rise)
	);

	wrc_bin2bcd u_gbcd
	(
		.bin (mag(st_r.gross_r)),
		.bcd (gbcd)
	);

	wrc_bin2bcd u_nbcd
	(
		.bin (mag(st_r.net_r)),
		.bcd (nbcd)
	);

	assign soft_lock  = st_r.cmd0_r[wrc_pkg::B_SLOCK];
	assign hold       = st_r.cmd0_r[wrc_pkg::B_HOLD];
	assign gross_live = gross_raw - (st_r.zeroing_trigger_r ? st_r.zero_off_r : 18'h00000);
	assign net_live   = gross_live - (st_r.tare_on_r ? st_r.tare_r : 18'h00000);
	assign w          = {st_r.net_r[17], st_r.net_r};
	assign fin        = u19(setv(st_r.live_r, wrc_pkg::W_FINAL));
	// Compensation enable from relay bit or setting
	assign ffc_en     = st_r.cfg_r[wrc_pkg::C_FFREL] ? st_r.cmd0_r[wrc_pkg::B_FFC]
		: st_r.cfg_r[wrc_pkg::C_FFSET];
	// Direction from relay bit or setting
	assign discharge  = st_r.cfg_r[wrc_pkg::C_FDREL] ? st_r.cmd0_r[wrc_pkg::B_FD]
		: st_r.cfg_r[wrc_pkg::C_FDSET];
	assign t1         = fin - u19(setv(st_r.live_r, wrc_pkg::W_SP1));
	assign t2         = fin - u19(setv(st_r.live_r, wrc_pkg::W_SP2));
	assign t3         = fin - u19(ffc_en ? {1'b0, st_r.live_r[wrc_pkg::W_FFC]} : 17'h00000);
	assign ov_t       = fin + u19({1'b0, st_r.live_r[wrc_pkg::W_OVER]});
	assign un_t       = fin - u19({1'b0, st_r.live_r[wrc_pkg::W_UNDER]});
	assign quart      = {2'b00, fin[18:2]};
	assign sp_cmp     = {w >= t3, w >= t2, w >= t1};
	assign near_cmp   = w <= u19(setv(st_r.live_r, wrc_pkg::W_NEAR));
	assign tare_act   = st_r.tare_on_r && (st_r.tare_r != 18'h00000);
	// Sequence completion freezes the reported weight
	assign freeze     = hold || (st_r.cfg_r[wrc_pkg::C_SEQ] && st_r.complete_r);
	assign cal_busy   = st_r.cal_zero_r | st_r.cal_span_r;
	assign dz_ok      = mag(gross_raw) <= {1'b0, st_r.cfg_r[wrc_pkg::C_DZR +: 16]};
	assign mb_off     = paddr - wrc_pkg::A_MBOX;
	assign mb_hit     = (paddr >= wrc_pkg::A_MBOX) && (paddr <= wrc_pkg::A_MEND)
		&& (paddr[1:0] == 2'b00);
	assign acc_wr     = psel & penable & st_r.pready_r & pwrite;

	// Status words; sign decimal code
	assign stg = {st_r.ou_r, st_r.complete_r, st_r.sp_r[2], st_r.sp_r[1], st_r.sp_r[0],
		st_r.near_r, st_r.cfg_r[wrc_pkg::C_DEC +: 2], st_r.gross_r[17], 1'b0, gbcd};
	assign stn = {~discharge, tare_act, hold, st_r.cfg_r[wrc_pkg::C_ZT],
		center_interval_flag, stable_in, st_r.upper_r, st_r.lower_r,
		st_r.cfg_r[wrc_pkg::C_DEC +: 2], st_r.net_r[17], 1'b0, nbcd};
	assign stm = {2'b00, st_r.zero_err_r, 5'h00, st_r.asst_r, st_r.code_r,
		1'b0, 1'b1, st_r.code_r != 4'h0, 6'h00,
		st_r.xf_busy_r & st_r.xf_wr_r, st_r.cal_span_r, st_r.cal_zero_r, dip_sw};

	always_comb
	begin
		logic [31:0] rv;
		logic        ok;
		rv = 32'h0000_0000;
		ok = 1'b1;
		st_nxt = st_r;

		case (paddr)
			wrc_pkg::A_CMD0: rv = {16'h0000, st_r.cmd0_r};
			wrc_pkg::A_CMD1: rv = {16'h0000, st_r.cmd1_r};
			wrc_pkg::A_STG:  rv = stg;
			wrc_pkg::A_STN:  rv = stn;
			wrc_pkg::A_STM:  rv = stm;
			wrc_pkg::A_CFG:  rv = st_r.cfg_r;
			wrc_pkg::A_CALZ: rv = {15'h0000, st_r.calz_r};
			wrc_pkg::A_CALS: rv = {15'h0000, st_r.cals_r};
			default:
			begin
				if (mb_hit)
					rv = {16'h0000, st_r.mbox_r[mb_off[6:2]]};
				else
					ok = 1'b0;
			end
		endcase
		// Calibration writes refused while soft lock is set
		if (pwrite && soft_lock && (paddr == wrc_pkg::A_CALZ || paddr == wrc_pkg::A_CALS))
			ok = 1'b0;

		st_nxt.pready_r = psel & ~penable;
		if (psel & ~penable)
		begin
			st_nxt.prdata_r  = pwrite ? 32'h0000_0000 : rv;
			st_nxt.pslverr_r = ~ok;
		end

		if (acc_wr && ok)
		begin
			case (paddr)
				wrc_pkg::A_CMD0: st_nxt.cmd0_r = pwdata[15:0];
				wrc_pkg::A_CMD1: st_nxt.cmd1_r = pwdata[15:0];
				wrc_pkg::A_CFG:  st_nxt.cfg_r = pwdata;
				wrc_pkg::A_CALZ: st_nxt.calz_r = pwdata[16:0];
				wrc_pkg::A_CALS: st_nxt.cals_r = pwdata[16:0];
				default:
				begin
					if (mb_hit)
						st_nxt.mbox_r[mb_off[6:2]] = pwdata[15:0];
				end
			endcase
		end

		// Weight path, held while frozen
		if (!freeze)
		begin
			st_nxt.gross_r = gross_live;
			st_nxt.net_r   = net_live;
		end

		if (st_r.cfg_r[wrc_pkg::C_TREL])
		begin
			// Relay-driven tare subtraction
			st_nxt.tare_on_r = st_r.cmd0_r[wrc_pkg::B_DTARE];
			if (rise[wrc_pkg::B_DTARE])
				st_nxt.tare_r = gross_live;
		end
		else
		begin
			if (rise[wrc_pkg::B_TARE_ON] && (!st_r.cfg_r[wrc_pkg::C_TRESTR] || stable_in))
			begin
				st_nxt.tare_r    = gross_live;
				st_nxt.tare_on_r = 1'b1;
			end
			if (rise[wrc_pkg::B_TARE_OFF])
				st_nxt.tare_on_r = 1'b0;
		end

		if (rise[wrc_pkg::B_ZEROING_TRIGGER])
		begin
			if (dz_ok)
			begin
				st_nxt.zero_off_r = gross_raw;
				st_nxt.zeroing_trigger_r    = 1'b1;
			end
			else
				st_nxt.zero_err_r = 1'b1;
		end
		if (rise[wrc_pkg::B_ZEROING_CANCEL])
		begin
			st_nxt.zeroing_trigger_r    = 1'b0;
			// A failed zeroing in the same cycle wins over the clear
			st_nxt.zero_err_r = rise[wrc_pkg::B_ZEROING_TRIGGER] && !dz_ok;
		end

		// Comparisons are held along with the weight while hold is on
		if (!hold)
		begin
			st_nxt.near_r = near_cmp;
			if (!st_r.cfg_r[wrc_pkg::C_LIMEXT] || st_r.cmd0_r[wrc_pkg::B_JUDGE])
			begin
				st_nxt.lower_r = w < u19(setv(st_r.live_r, wrc_pkg::W_LOWER));
				st_nxt.upper_r = w > u19(setv(st_r.live_r, wrc_pkg::W_UPPER));
			end
			else
			begin
				st_nxt.lower_r = 1'b0;
				st_nxt.upper_r = 1'b0;
			end
			if (st_r.cfg_r[wrc_pkg::C_SEQ])
				st_nxt.ou_r = st_r.complete_r ? ouj(
					{st_r.judge_w_r[17], st_r.judge_w_r}, ov_t, un_t, t3) : 3'b000;
			else if (!st_r.cfg_r[wrc_pkg::C_OUEXT] || st_r.cmd0_r[wrc_pkg::B_JUDGE])
				st_nxt.ou_r = ouj(w, ov_t, un_t, t3);
			else
				st_nxt.ou_r = 3'b000;
		end

		// Rearm completion once weight drops under a quarter of final
		if (w < quart)
			st_nxt.armed_r = 1'b1;

		if (rise[wrc_pkg::B_STOP] && st_r.seq_r == wrc_pkg::SEQ_RUN)
		begin
			st_nxt.seq_r  = wrc_pkg::SEQ_IDLE;
			st_nxt.asst_r = wrc_pkg::ERR_ASST_SEQ;
			st_nxt.code_r = wrc_pkg::ERR_CODE_STOP;
		end
		else if (rise[wrc_pkg::B_STOP] && st_r.asst_r == wrc_pkg::ERR_ASST_SEQ)
		begin
			st_nxt.asst_r = 4'h0;
			st_nxt.code_r = 4'h0;
		end
		else if (!st_r.cfg_r[wrc_pkg::C_SEQ])
		begin
			st_nxt.seq_r      = wrc_pkg::SEQ_IDLE;
			st_nxt.complete_r = 1'b0;
			if (!hold)
				st_nxt.sp_r = sp_cmp;
		end
		else if (rise[wrc_pkg::B_START])
		begin
			st_nxt.seq_r      = wrc_pkg::SEQ_RUN;
			st_nxt.sp_r       = 3'b111;
			st_nxt.complete_r = 1'b0;
		end
		else
		begin
			unique case (st_r.seq_r)
				wrc_pkg::SEQ_IDLE:
				begin
				end
				wrc_pkg::SEQ_RUN:
				begin
					st_nxt.sp_r = st_r.sp_r & ~sp_cmp;
					if (st_r.sp_r[2] && sp_cmp[2])
					begin
						st_nxt.seq_r = wrc_pkg::SEQ_DONE;
						// Judging count zero: complete on flag fall if armed
						if (st_r.armed_r || !st_r.cfg_r[wrc_pkg::C_OUZERO])
						begin
							st_nxt.complete_r = 1'b1;
							st_nxt.armed_r    = 1'b0;
							st_nxt.judge_w_r  = st_r.net_r;
						end
					end
				end
				wrc_pkg::SEQ_DONE:
				begin
				end
			endcase
		end

		// Calibration start, ignored when locked or busy
		if ((rise[wrc_pkg::B_ZCAL] || rise[wrc_pkg::B_SCAL]) && !soft_lock && !lock_switch
			&& !cal_busy)
		begin
			st_nxt.cal_zero_r = rise[wrc_pkg::B_ZCAL];
			st_nxt.cal_span_r = ~rise[wrc_pkg::B_ZCAL];
			st_nxt.cal_cnt_r  = wrc_pkg::CAL_CYCLES;
		end
		else if (cal_busy)
		begin
			st_nxt.cal_cnt_r = st_r.cal_cnt_r - 8'h01;
			if (st_r.cal_cnt_r == 8'h01)
			begin
				st_nxt.cal_zero_r = 1'b0;
				st_nxt.cal_span_r = 1'b0;
				if (st_r.cal_zero_r)
					st_nxt.calz_r = gross_raw[16:0];
				else
					st_nxt.cals_r = gross_raw[16:0];
			end
		end

		// Settings block exchange, one word per cycle
		if (st_r.xf_busy_r)
		begin
			if (st_r.xf_wr_r)
				st_nxt.live_r[st_r.xf_idx_r] = st_r.mbox_r[st_r.xf_idx_r];
			else
				st_nxt.mbox_r[st_r.xf_idx_r] = st_r.live_r[st_r.xf_idx_r];
			st_nxt.xf_idx_r  = st_r.xf_idx_r + 5'h01;
			st_nxt.xf_busy_r = st_r.xf_idx_r != wrc_pkg::MB_LAST;
		end
		else if (rise[wrc_pkg::B_REQ])
		begin
			st_nxt.xf_busy_r = 1'b1;
			st_nxt.xf_wr_r   = st_r.cmd1_r[wrc_pkg::B_RW - 16];
			st_nxt.xf_idx_r  = 5'h00;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r         <= '0;
			st_r.cfg_r   <= wrc_pkg::CFG_RST;
			st_r.armed_r <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign prdata  = st_r.prdata_r;
	assign pready  = st_r.pready_r;
	assign pslverr = st_r.pslverr_r;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Length of the current busy run; a gap restarts it, so the check sees one run
	logic [4:0] xf_len_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			xf_len_r <= 5'h00;
		else if (st_r.xf_busy_r)
			xf_len_r <= xf_len_r + 5'h01;
		else
			xf_len_r <= 5'h00;
	end

	sequence s_xfer_go;
		rise[wrc_pkg::B_REQ] && !st_r.xf_busy_r;
	endsequence
	sequence s_xfer_run;
		(st_r.xf_busy_r && xf_len_r == 5'h00) ##19 (st_r.xf_busy_r && xf_len_r == 5'h13)
			##1 (!st_r.xf_busy_r && xf_len_r == 5'h14);
	endsequence

	a_seq_abort: assert property (rise[wrc_pkg::B_STOP] && st_r.seq_r == wrc_pkg::SEQ_RUN
		|=> st_r.asst_r == 4'h3 && st_r.code_r == 4'h2 && st_r.seq_r == wrc_pkg::SEQ_IDLE)
		else $error("stop edge did not abort sequence");
	a_sequence_start_bit_flags: assert property (st_r.cfg_r[0] && rise[wrc_pkg::B_START]
		&& !rise[wrc_pkg::B_STOP] |=> st_r.sp_r == 3'b111 && !st_r.complete_r)
		else $error("sequence start did not set flags");
	a_tare_cancel: assert property (!st_r.cfg_r[2] && rise[wrc_pkg::B_TARE_OFF]
		&& !rise[wrc_pkg::B_TARE_ON] |=> !st_r.tare_on_r && $stable(st_r.tare_r))
		else $error("tare cancel misbehaved");
	a_cal_locked: assert property ((rise[16] || rise[17]) && soft_lock && !cal_busy
		|=> !cal_busy)
		else $error("calibration started under lock");
	a_hold_freeze: assert property (hold |=> $stable(st_r.net_r) && $stable(st_r.gross_r))
		else $error("weight moved during hold");
	a_xfer_len: assert property (s_xfer_go |=> s_xfer_run)
		else $error("settings exchange not twenty cycles");
	a_near_zero: assert property (!hold |=> st_r.near_r == $past(near_cmp))
		else $error("near zero flag wrong");
	a_complete_rise: assert property ($rose(st_r.complete_r)
		|-> $past(st_r.sp_r[2]) && !st_r.sp_r[2])
		else $error("complete rose without third flag fall");
	a_zero_error: assert property (rise[wrc_pkg::B_ZEROING_TRIGGER] && !dz_ok
		|=> st_r.zero_err_r)
		else $error("out of range zeroing without error");
endmodule

/* File: verilog/wrc_pkg.sv */
// Constants and types shared by the weighing relay command block
package wrc_pkg;
	localparam int WW = 18;

	// Register byte addresses
	localparam logic [7:0] A_CMD0 = 8'h00;
	localparam logic [7:0] A_CMD1 = 8'h04;
	localparam logic [7:0] A_STG  = 8'h08;
	localparam logic [7:0] A_STN  = 8'h0c;
	localparam logic [7:0] A_STM  = 8'h10;
	localparam logic [7:0] A_CFG  = 8'h14;
	localparam logic [7:0] A_CALZ = 8'h18;
	localparam logic [7:0] A_CALS = 8'h1c;
	localparam logic [7:0] A_MBOX = 8'h40;
	localparam logic [7:0] A_MEND = 8'h8c;
	localparam logic [4:0] MB_LAST = 5'h13;

	// Command bit positions in {cmd1, cmd0}
	localparam int B_TARE_ON  = 0;
	localparam int B_TARE_OFF = 1;
	localparam int B_ZEROING_TRIGGER    = 2;
	localparam int B_ZEROING_CANCEL   = 3;
	localparam int B_HOLD     = 4;
	localparam int B_DTARE    = 5;
	localparam int B_FD       = 6;
	localparam int B_FFC      = 8;
	localparam int B_JUDGE    = 9;
	localparam int B_START    = 10;
	localparam int B_STOP     = 11;
	localparam int B_SLOCK    = 13;
	localparam int B_ZCAL     = 16;
	localparam int B_SCAL     = 17;
	localparam int B_REQ      = 28;
	localparam int B_RW       = 30;

	// Configuration bit positions
	localparam int C_SEQ    = 0;
	localparam int C_TRESTR = 1;
	localparam int C_TREL   = 2;
	localparam int C_FDREL  = 3;
	localparam int C_FFREL  = 4;
	localparam int C_OUEXT  = 5;
	localparam int C_LIMEXT = 6;
	localparam int C_OUZERO = 7;
	localparam int C_DEC    = 8;
	localparam int C_ZT     = 10;
	localparam int C_FDSET  = 11;
	localparam int C_FFSET  = 12;
	localparam int C_DZR    = 16;
	localparam logic [31:0] CFG_RST = 32'h0064_0080;

	// Settings word indices
	localparam int W_UPPER = 0;
	localparam int W_LOWER = 2;
	localparam int W_NEAR  = 4;
	localparam int W_SP1   = 6;
	localparam int W_SP2   = 8;
	localparam int W_FFC   = 10;
	localparam int W_OVER  = 11;
	localparam int W_UNDER = 12;
	localparam int W_FINAL = 13;

	localparam logic [7:0] CAL_CYCLES    = 8'h40;
	localparam logic [3:0] ERR_ASST_SEQ  = 4'h3;
	localparam logic [3:0] ERR_CODE_STOP = 4'h2;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_RUN  = 2'b01,
		SEQ_DONE = 2'b11
	} wrc_seq_t;
endpackage

/* File: verilog/wrc_edge.sv */
// Rising-edge detector for the host command bits
`timescale 1ns/100ps
module wrc_edge
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [31:0] bits,
	output logic      [31:0] rise
);
	typedef struct packed {
		logic [31:0] prev_r;
	} wrc_edge_st_t;

	wrc_edge_st_t st_r;
	wrc_edge_st_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.prev_r = bits;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// One pulse per 0-to-1 change of a sampled bit
	assign rise = bits & ~st_r.prev_r;
endmodule

/* File: verilog/wrc_bin2bcd.sv */
// Binary to five packed decimal digits
`timescale 1ns/100ps
module wrc_bin2bcd
(
	input  wire logic [16:0] bin,
	output logic      [19:0] bcd
);
	always_comb
	begin
		logic [36:0] sh;
		sh = {20'h00000, bin};
		for (int i = 0; i < 17; i++)
		begin
			for (int k = 0; k < 5; k++)
			begin
				if (sh[17 + 4 * k +: 4] >= 4'h5)
					sh[17 + 4 * k +: 4] = sh[17 + 4 * k +: 4] + 4'h3;
			end
			sh = {sh[35:0], 1'b0};
		end
		// Five packed digits per weight
		bcd = sh[36:17];
	end
endmodule

/* File: testbench/wrc_host.sv */
// Host side model: APB master issuing command and settings traffic
`timescale 1ns/100ps
module wrc_host
(
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// Held until pready; released lines show inverted values, not stale ones
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask

	// Direction travels in the same word as the request edge
	task automatic exchange(input logic dir);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, wrc_pkg::A_CMD1, {17'h0, dir, 14'h1000}, q, e);
		xfer(1'b1, wrc_pkg::A_CMD1, 32'h0000_0000, q, e);
	endtask

	// Soft lock dropped before any calibration change
	task automatic unlock();
		logic [31:0] q;
		logic        e;
		xfer(1'b1, wrc_pkg::A_CMD0, 32'h0000_0000, q, e);
	endtask
endmodule

/* File: testbench/test_weigh_relay_command_status.sv */
// Self-checking bench of the weighing relay command block
`timescale 1ns/100ps
module test_weigh_relay_command_status;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        stable_in = 1'b0;
	logic        lock_switch = 1'b0;
	logic [17:0] gross_raw = 18'h0;
	wire         psel, penable, pwrite;
	wire  [7:0]  paddr;
	wire  [31:0] pwdata;
	logic [31:0] prdata, q;
	logic        pready, pslverr, e;
	int          failures = 0;
	int          check_count = 0;
	int          cycles = 0;
	logic [15:0] mb [20] = '{16'd2000, 0, 16'd50, 0, 16'd10, 0, 16'd200, 0, 16'd100, 0,
		16'd10, 16'd5, 16'd5, 16'd1000, 0, 0, 0, 0, 0, 0};
	logic [17:0] tg [5] = '{18'd950, 18'd995, 18'd1006, 18'd5, 18'd2001};
	logic [31:0] ts [5] = '{32'h2600_0000, 32'h4e00_0000, 32'h8e00_0000, 32'h2100_0000,
		32'h8e00_0000};
	logic [31:0] tn [5] = '{32'h0, 32'h0, 32'h0, 32'h0100_0000, 32'h0200_0000};
	localparam logic [31:0] CR = wrc_pkg::CFG_RST;

	always #12.5 pclk = ~pclk;

	wrc_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	wrc_weigh_relay dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .gross_raw(gross_raw), .stable_in(stable_in),
		.lock_switch(lock_switch), .center_interval_flag(1'b0), .dip_sw(4'h5));

	task automatic finish_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			finish_test();
		end
	end

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] x);
		host.xfer(1'b0, a, 32'h0, q, e);
		chk(n, x, q & m);
	endtask

	// Settling gap so edge detection and status update land before the next read
	task automatic cmd(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, q, e);
		repeat (3) @(posedge pclk);
	endtask

	task automatic pulse(input logic [7:0] a, input int b);
		cmd(a, 32'h1 << b);
		cmd(a, 32'h0);
	endtask

	task automatic setw(input logic [17:0] v);
		@(posedge pclk);
		gross_raw <= v;
		repeat (3) @(posedge pclk);
	endtask

	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		host.xfer(1'b0, 8'h20, 32'h0, q, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		setw(18'd12345);
		rchk("gross", wrc_pkg::A_STG, 32'h003f_ffff, 32'h0001_2345);
		setw(-18'sd50);
		rchk("gross neg", wrc_pkg::A_STG, 32'h003f_ffff, 32'h0020_0050);
		rchk("net neg", wrc_pkg::A_STN, 32'h003f_ffff, 32'h0020_0050);
		for (int i = 0; i < 4; i++)
		begin
			cmd(wrc_pkg::A_CFG, CR | (i << 8));
			rchk("decimal", wrc_pkg::A_STG, 32'h00c0_0000, i << 22);
		end
		cmd(wrc_pkg::A_CFG, CR);
		setw(18'd100);
		pulse(wrc_pkg::A_CMD0, 0);
		rchk("tare", wrc_pkg::A_STN, 32'h400f_ffff, 32'h4000_0000);
		pulse(wrc_pkg::A_CMD0, 1);
		rchk("tare off", wrc_pkg::A_STN, 32'h400f_ffff, 32'h0000_0100);
		cmd(wrc_pkg::A_CFG, CR | 32'h2);
		pulse(wrc_pkg::A_CMD0, 0);
		rchk("tare unstable", wrc_pkg::A_STN, 32'h400f_ffff, 32'h0000_0100);
		cmd(wrc_pkg::A_CFG, CR);
		cmd(wrc_pkg::A_CMD0, 32'h10);
		setw(18'd300);
		rchk("hold", wrc_pkg::A_STN, 32'h200f_ffff, 32'h2000_0100);
		cmd(wrc_pkg::A_CMD0, 32'h0);
		rchk("unhold", wrc_pkg::A_STN, 32'h200f_ffff, 32'h0000_0300);
		// Range edge: 100 accepted, 101 refused
		setw(18'd100);
		pulse(wrc_pkg::A_CMD0, 2);
		rchk("zeroed", wrc_pkg::A_STG, 32'h000f_ffff, 32'h0);
		setw(18'd101);
		pulse(wrc_pkg::A_CMD0, 2);
		rchk("zero err", wrc_pkg::A_STM, 32'h2000_0000, 32'h2000_0000);
		pulse(wrc_pkg::A_CMD0, 3);
		rchk("zero err clr", wrc_pkg::A_STM, 32'h2000_0000, 32'h0);
		rchk("zero off", wrc_pkg::A_STG, 32'h000f_ffff, 32'h0000_0101);
		cmd(wrc_pkg::A_CFG, CR | 32'h8);
		cmd(wrc_pkg::A_CMD0, 32'h40);
		rchk("discharge", wrc_pkg::A_STN, 32'h8000_0000, 32'h0);
		cmd(wrc_pkg::A_CMD0, 32'h0);
		rchk("feed", wrc_pkg::A_STN, 32'h8000_0000, 32'h8000_0000);
		cmd(wrc_pkg::A_CFG, CR | 32'h4);
		cmd(wrc_pkg::A_CMD0, 32'h20);
		rchk("relay tare", wrc_pkg::A_STN, 32'h400f_ffff, 32'h4000_0000);
		cmd(wrc_pkg::A_CMD0, 32'h0);
		rchk("relay tare off", wrc_pkg::A_STN, 32'h400f_ffff, 32'h0000_0101);
		cmd(wrc_pkg::A_CFG, CR);
		for (int i = 0; i < 20; i++)
			host.xfer(1'b1, wrc_pkg::A_MBOX + 8'(4 * i), {16'h0, mb[i]}, q, e);
		host.exchange(1'b1);
		rchk("nov busy", wrc_pkg::A_STM, 32'h40, 32'h40);
		repeat (25) @(posedge pclk);
		rchk("nov idle", wrc_pkg::A_STM, 32'h40, 32'h0);
		// Compensation on through the relay bit for the judgment table
		cmd(wrc_pkg::A_CFG, CR | 32'h10);
		cmd(wrc_pkg::A_CMD0, 32'h100);
		for (int i = 0; i < 5; i++)
		begin
			setw(tg[i]);
			rchk("judge flags", wrc_pkg::A_STG, 32'hef00_0000, ts[i]);
			rchk("limits", wrc_pkg::A_STN, 32'h0300_0000, tn[i]);
		end
		cmd(wrc_pkg::A_CMD0, 32'h0);
		setw(18'd995);
		rchk("ffc off", wrc_pkg::A_STG, 32'h4800_0000, 32'h0);
		setw(18'd2001);
		cmd(wrc_pkg::A_CFG, CR | 32'h20);
		rchk("judge gated", wrc_pkg::A_STG, 32'h8000_0000, 32'h0);
		cmd(wrc_pkg::A_CMD0, 32'h200);
		rchk("judge on", wrc_pkg::A_STG, 32'h8000_0000, 32'h8000_0000);
		cmd(wrc_pkg::A_CMD0, 32'h0);
		cmd(wrc_pkg::A_CFG, CR | 32'h1001);
		setw(18'd101);
		pulse(wrc_pkg::A_CMD0, 10);
		rchk("seq flags", wrc_pkg::A_STG, 32'h0e00_0000, 32'h0e00_0000);
		pulse(wrc_pkg::A_CMD0, 11);
		rchk("seq abort", wrc_pkg::A_STM, 32'h00ff_2000, 32'h0032_2000);
		pulse(wrc_pkg::A_CMD0, 11);
		rchk("seq err clr", wrc_pkg::A_STM, 32'h00ff_2000, 32'h0);
		pulse(wrc_pkg::A_CMD0, 10);
		setw(18'd995);
		rchk("seq done", wrc_pkg::A_STG, 32'h1e00_0000, 32'h1000_0000);
		cmd(wrc_pkg::A_CFG, CR);
		setw(18'd291);
		cmd(wrc_pkg::A_CMD0, 32'h2000);
		host.xfer(1'b1, wrc_pkg::A_CALZ, 32'h5, q, e);
		chk("cal locked", 32'h1, {31'h0, e});
		pulse(wrc_pkg::A_CMD1, 0);
		rchk("cal soft lock", wrc_pkg::A_STM, 32'h30, 32'h0);
		host.unlock();
		lock_switch <= 1'b1;
		pulse(wrc_pkg::A_CMD1, 1);
		rchk("cal lock_switch", wrc_pkg::A_STM, 32'h30, 32'h0);
		lock_switch <= 1'b0;
		pulse(wrc_pkg::A_CMD1, 0);
		pulse(wrc_pkg::A_CMD1, 1);
		rchk("cal busy", wrc_pkg::A_STM, 32'h30, 32'h10);
		repeat (70) @(posedge pclk);
		rchk("cal end", wrc_pkg::A_STM, 32'h30, 32'h0);
		rchk("cal value", wrc_pkg::A_CALZ, 32'hffff_ffff, 32'h0000_0123);
		finish_test();
	end
endmodule
